// ### core/isrb_pkg.sv
// Purpose: Shared constants for the impedance sweep register bank
// Assumes: Byte-wide register port, one clock, active-low async reset
// Notes: Offsets are byte addresses on the register port
package isrb_pkg;
	localparam logic [7:0] ADDR_CTRL_HI = 8'h80;
	localparam logic [7:0] ADDR_CTRL_LO = 8'h81;
	localparam logic [7:0] ADDR_START_0 = 8'h82;
	localparam logic [7:0] ADDR_STEP_0 = 8'h85;
	localparam logic [7:0] ADDR_COUNT_0 = 8'h88;
	localparam logic [7:0] ADDR_SETTLE_0 = 8'h8A;
	localparam logic [7:0] ADDR_STATUS = 8'h8F;
	localparam logic [7:0] ADDR_REAL_HI = 8'h94;
	localparam logic [7:0] ADDR_REAL_LO = 8'h95;
	localparam logic [7:0] ADDR_IMAG_HI = 8'h96;
	localparam logic [7:0] ADDR_IMAG_LO = 8'h97;
	localparam logic [15:0] CTRL_RESET = 16'hA000;
	localparam logic [23:0] FREQ_RESET = 24'h000000;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam int CMD_MSB = 15;
	localparam int CMD_LSB = 12;
	localparam int UNUSED_BIT = 11;
	localparam int RANGE_MSB = 10;
	localparam int RANGE_LSB = 9;
	localparam int GAIN_BIT = 8;
	localparam int CLKSRC_BIT = 3;
	localparam int RESET_BIT = 4;
	// Command codes of the upper nibble
	typedef enum logic [3:0]
	{
		ISRB_CMD_NOP = 4'h0,
		ISRB_CMD_INIT = 4'h1,
		ISRB_CMD_SWEEP = 4'h2,
		ISRB_CMD_STEP = 4'h3,
		ISRB_CMD_REPEAT = 4'h4,
		ISRB_CMD_PWRDN = 4'hA,
		ISRB_CMD_STBY = 4'hB
	} isrb_cmd_e;
	// Excitation range numbers
	typedef enum logic [1:0]
	{
		ISRB_RANGE_1 = 2'h0,
		ISRB_RANGE_2 = 2'h1,
		ISRB_RANGE_3 = 2'h2,
		ISRB_RANGE_4 = 2'h3
	} isrb_range_e;
endpackage

// ### core/isrb_byte_reg.sv
// Purpose: One byte lane of a writable register
// Assumes: Write strobe is one cycle wide
// Notes: Reset value is set per instance
module isrb_byte_reg #(
	parameter logic [7:0] RESET_VAL = 8'h00
)
(
	input wire logic sys_clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic wrEn, // Load strobe
	input wire logic [7:0] wrData, // Byte to load
	output logic [7:0] value // Stored byte
);
	// Plain byte storage
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			value <= RESET_VAL;
		else if (wrEn)
			value <= wrData;
	end
endmodule

// ### core/isrb_bank.sv
// Purpose: Register bank of an impedance sweep converter
// Assumes: Serial bus front end already yields byte address, write strobe and read data path
// Notes: Read data is registered; one cycle from read strobe to rdValid
// Notes on behaviour
// - Sixteen-bit control register, upper byte at 0x80, lower byte at 0x81.
// - Control register resets to 0xA000 at power-up.
// - Top four control bits decode as the command field.
// - Writing only the upper control byte leaves the lower byte unchanged.
// - Reset command leaves start frequency, step and step count untouched.
// - After reset command, sweep waits for an initialize-with-start-frequency command.
// - Range field: 00 2V, 01 200mV, 10 400mV, 11 1V peak-to-peak.
// - Control bit eleven has no effect whatever its value.
// - Control register also holds excitation range and clock source selection.
// - Control bit eight picks gain: 0 is times five, 1 times one.
module isrb_bank
(
	input wire logic sys_clk, // System clock, 20 MHz
	input wire logic rst_n, // Async reset, active low
	input wire logic [7:0] busAddr, // Register byte address
	input wire logic busWrite, // Byte write strobe
	input wire logic busBlock, // Write belongs to a block write
	input wire logic [7:0] busWrData, // Write byte
	input wire logic busRead, // Byte read strobe
	output logic [7:0] busRdData, // Read byte
	output logic rdValid, // Read data valid pulse
	output logic rdMapped, // Last read hit a mapped address
	input wire logic [7:0] engineStatus, // Status byte from sweep engine
	input wire logic [15:0] engineReal, // Real result from datapath
	input wire logic [15:0] engineImag, // Imaginary result from datapath
	output logic [23:0] sweepStartFreq, // Start frequency word
	output logic [23:0] sweepFreqStep, // Frequency increment word
	output logic [15:0] sweepStepCount, // Sweep_step_count
	output logic [15:0] settleCycleCount, // Settling cycles
	output logic [3:0] sweepCmd, // Command field
	output logic cmdStrobe, // Pulse on upper control byte write
	output logic sweepArmed, // Sweep may run
	output logic [1:0] excitationRange, // Range number minus one
	output logic gainSelectBit, // High for unity gain
	output logic gainTimesFive, // Amplifier at times five
	output logic extClockSel, // External clock selected
	output logic softReset // Reset command held
);
	import isrb_pkg::*;

	logic [15:0] controlWord;
	logic [7:0] ctrlHi;
	logic [7:0] ctrlLo;
	logic [23:0] freqStart;
	logic [23:0] freqStep;
	logic [15:0] stepCount;
	logic [15:0] settleCount;
	logic ctrlHiWr;
	logic ctrlLoWr;
	logic [7:0] next_rdData;
	logic next_mapped;
	logic armed;

	// Control writes are single-byte only; block writes are dropped to protect command decode
	assign ctrlHiWr = busWrite && !busBlock && (busAddr == ADDR_CTRL_HI);
	assign ctrlLoWr = busWrite && !busBlock && (busAddr == ADDR_CTRL_LO);

	// Control bytes kept apart so an upper-byte write cannot disturb the lower byte
	isrb_byte_reg #(.RESET_VAL(CTRL_RESET[15:8])) uCtrlHi
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wrEn(ctrlHiWr),
		.wrData(busWrData),
		.value(ctrlHi)
	);
	isrb_byte_reg #(.RESET_VAL(CTRL_RESET[7:0])) uCtrlLo
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wrEn(ctrlLoWr),
		.wrData(busWrData),
		.value(ctrlLo)
	);

	// Both byte lanes joined into one word; each lane still has a single driver
	assign controlWord = {ctrlHi, ctrlLo};

	// Start frequency, MSB at the lowest address; a reset command never reaches it
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			freqStart <= FREQ_RESET;
		else if (busWrite)
		begin
			unique case (busAddr)
				ADDR_START_0: freqStart[23:16] <= busWrData;
				ADDR_START_0 + 8'h01: freqStart[15:8] <= busWrData;
				ADDR_START_0 + 8'h02: freqStart[7:0] <= busWrData;
				default: ; // Other addresses belong to other registers
			endcase
		end
	end

	// Frequency increment, kept across a reset command
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			freqStep <= FREQ_RESET;
		else if (busWrite)
		begin
			unique case (busAddr)
				ADDR_STEP_0: freqStep[23:16] <= busWrData;
				ADDR_STEP_0 + 8'h01: freqStep[15:8] <= busWrData;
				ADDR_STEP_0 + 8'h02: freqStep[7:0] <= busWrData;
				default: ; // Other addresses belong to other registers
			endcase
		end
	end

	// Sweep_step_count, kept across a reset command
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			stepCount <= WORD_RESET;
		else if (busWrite)
		begin
			unique case (busAddr)
				ADDR_COUNT_0: stepCount[15:8] <= busWrData;
				ADDR_COUNT_0 + 8'h01: stepCount[7:0] <= busWrData;
				default: ; // Other addresses belong to other registers
			endcase
		end
	end

	// Settling cycles; read-only and unmapped addresses fall through every setup block
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			settleCount <= WORD_RESET;
		else if (busWrite)
		begin
			unique case (busAddr)
				ADDR_SETTLE_0: settleCount[15:8] <= busWrData;
				ADDR_SETTLE_0 + 8'h01: settleCount[7:0] <= busWrData;
				default: ; // Status, results and unmapped addresses ignore writes
			endcase
		end
	end

	// Armed state: cleared by reset command, set again only by initialize command
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			armed <= 1'b0;
		else if (ctrlLoWr && busWrData[RESET_BIT])
			armed <= 1'b0;
		else if (ctrlHiWr && (busWrData[7:4] == ISRB_CMD_INIT))
			armed <= 1'b1;
	end

	// Read mux picks the addressed byte
	always_comb
	begin
		next_rdData = 8'h00;
		next_mapped = 1'b1;
		unique case (busAddr)
			ADDR_CTRL_HI: next_rdData = controlWord[15:8];
			ADDR_CTRL_LO: next_rdData = controlWord[7:0];
			ADDR_START_0: next_rdData = freqStart[23:16];
			ADDR_START_0 + 8'h01: next_rdData = freqStart[15:8];
			ADDR_START_0 + 8'h02: next_rdData = freqStart[7:0];
			ADDR_STEP_0: next_rdData = freqStep[23:16];
			ADDR_STEP_0 + 8'h01: next_rdData = freqStep[15:8];
			ADDR_STEP_0 + 8'h02: next_rdData = freqStep[7:0];
			ADDR_COUNT_0: next_rdData = stepCount[15:8];
			ADDR_COUNT_0 + 8'h01: next_rdData = stepCount[7:0];
			ADDR_SETTLE_0: next_rdData = settleCount[15:8];
			ADDR_SETTLE_0 + 8'h01: next_rdData = settleCount[7:0];
			ADDR_STATUS: next_rdData = engineStatus;
			ADDR_REAL_HI: next_rdData = engineReal[15:8];
			ADDR_REAL_LO: next_rdData = engineReal[7:0];
			ADDR_IMAG_HI: next_rdData = engineImag[15:8];
			ADDR_IMAG_LO: next_rdData = engineImag[7:0];
			default: next_mapped = 1'b0; // Unmapped reads return zero
		endcase
	end

	// Registered read answer
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busRdData <= 8'h00;
			rdValid <= 1'b0;
			rdMapped <= 1'b0;
		end
		else
		begin
			rdValid <= busRead;
			if (busRead)
			begin
				busRdData <= next_rdData;
				rdMapped <= next_mapped;
			end
		end
	end

	// Command strobe follows an accepted upper control byte write
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cmdStrobe <= 1'b0;
		else
			cmdStrobe <= ctrlHiWr;
	end

	// Field decode; bit eleven is deliberately left unread
	assign sweepCmd = controlWord[CMD_MSB:CMD_LSB];
	assign excitationRange = controlWord[RANGE_MSB:RANGE_LSB] == 2'h0 ? ISRB_RANGE_1 :
		controlWord[RANGE_MSB:RANGE_LSB] == 2'h1 ? ISRB_RANGE_3 :
		controlWord[RANGE_MSB:RANGE_LSB] == 2'h2 ? ISRB_RANGE_4 : ISRB_RANGE_2;
	assign gainSelectBit = controlWord[GAIN_BIT];
	assign gainTimesFive = !controlWord[GAIN_BIT];
	assign extClockSel = controlWord[CLKSRC_BIT];
	assign softReset = controlWord[RESET_BIT];
	assign sweepArmed = armed;
	assign sweepStartFreq = freqStart;
	assign sweepFreqStep = freqStep;
	assign sweepStepCount = stepCount;
	assign settleCycleCount = settleCount;
endmodule

// ### verification/isrb_bank_chk.sv
// Purpose: Port timing checks for the register bank
// Assumes: One clock, async active-low reset
// Notes: Bound to every bank instance
module isrb_bank_chk
(
	input wire logic sys_clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic [7:0] busAddr, // Address
	input wire logic busWrite, // Write strobe
	input wire logic busBlock, // Block flag
	input wire logic [7:0] busWrData, // Write byte
	input wire logic busRead, // Read strobe
	input wire logic rdValid, // Read valid
	input wire logic [23:0] sweepStartFreq, // Start word
	input wire logic [3:0] sweepCmd, // Command
	input wire logic cmdStrobe, // Command pulse
	input wire logic sweepArmed, // Armed
	input wire logic [1:0] excitationRange, // Range
	input wire logic gainSelectBit, // Gain bit
	input wire logic gainTimesFive // Gain x5
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Accepted upper control byte write; block writes must not count
	wire logic hiWr = busWrite && !busBlock && busAddr == 8'h80;
	property p_rd_lat; busRead |=> rdValid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read valid late");
	property p_strobe; cmdStrobe == $past(hiWr); endproperty
	a_strobe: assert property (p_strobe) else $error("command pulse wrong");
	property p_cmd; hiWr |=> sweepCmd == $past(busWrData[7:4]); endproperty
	a_cmd: assert property (p_cmd) else $error("command field wrong");
	property p_blk; busWrite && busBlock && busAddr == 8'h80 |=> $stable(sweepCmd); endproperty
	a_blk: assert property (p_blk) else $error("block write changed control");
	property p_range; hiWr |=> excitationRange == {^$past(busWrData[2:1]), $past(busWrData[2])}; endproperty
	a_range: assert property (p_range) else $error("range decode wrong");
	property p_gain; hiWr |=> gainSelectBit == $past(busWrData[0]) && gainTimesFive == !gainSelectBit; endproperty
	a_gain: assert property (p_gain) else $error("gain wrong");
	property p_arm; hiWr && busWrData[7:4] == 4'h1 |=> sweepArmed; endproperty
	a_arm: assert property (p_arm) else $error("init did not arm");
	property p_keep; busWrite && busAddr == 8'h81 |=> $stable(sweepStartFreq); endproperty
	a_keep: assert property (p_keep) else $error("start word disturbed");
endmodule
bind isrb_bank isrb_bank_chk chk (.*);

// ### verification/isrb_host.sv
// Purpose: Bus host model for the register bank
// Assumes: Signals change 1 ns after the rising edge
// Notes: Idle write data is inverted so a stale byte never looks valid
module isrb_host
(
	input wire logic sys_clk, // Clock
	input wire logic [7:0] busRdData, // Read byte
	input wire logic rdValid, // Read valid
	input wire logic rdMapped, // Read hit
	output logic [7:0] busAddr = 8'h00, // Address
	output logic busWrite = 1'b0, // Write strobe
	output logic busBlock = 1'b0, // Block flag
	output logic [7:0] busWrData = 8'h00, // Write byte
	output logic busRead = 1'b0 // Read strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	// One byte write; b high only where a scenario breaks the single-byte rule
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
		@(posedge sys_clk);
		#1;
		{busAddr, busWrData, busBlock, busWrite} = {a, d, b, 1'b1};
		@(posedge sys_clk);
		#1;
		busWrite = 1'b0;
		busWrData = ~d;
	endtask
	// One byte read, answer taken in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v, output logic m);
		@(posedge sys_clk);
		#1;
		{busAddr, busRead} = {a, 1'b1};
		@(posedge sys_clk);
		#1;
		busRead = 1'b0;
		{d, v, m} = {busRdData, rdValid, rdMapped};
	endtask
endmodule

// ### verification/tb.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Host model drives the byte port
// Notes: Engine inputs hold fixed patterns for read-only checks
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import isrb_pkg::*;
	logic sys_clk = 0, rst_n = 0, busWrite, busBlock, busRead, rdValid, rdMapped, cmdStrobe, sweepArmed, v, m;
	logic gainSelectBit, gainTimesFive, extClockSel, softReset;
	logic [7:0] busAddr, busWrData, busRdData, d, engineStatus = 8'h3C;
	logic [15:0] engineReal = 16'h1234, engineImag = 16'hBEEF, sweepStepCount, settleCycleCount;
	logic [23:0] sweepStartFreq, sweepFreqStep;
	logic [3:0] sweepCmd;
	logic [1:0] excitationRange;
	logic [1:0] rmap [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
	int error_cnt = 0, n_compared = 0;
	isrb_bank dut (.*);
	isrb_host host (.*);
	initial forever #25 sys_clk = ~sys_clk;
	// Wide enough for the joined setup words, so nothing is cut before the compare
	task chk(input logic [79:0] seen, input logic [79:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// Read with valid pulse and mapped flag checked too
	task rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d, v, m);
		chk({d, v, m}, {e, 2'h3});
	endtask
	task results;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard, about five times the expected run
	initial
	begin
		#20000;
		error_cnt++;
		results();
	end
	initial
	begin
		// Reset held over two rising edges, released just after the second
		repeat (2) @(posedge sys_clk);
		#1 rst_n = 1;
		rchk(ADDR_CTRL_HI, CTRL_RESET[15:8]);
		rchk(ADDR_CTRL_LO, CTRL_RESET[7:0]);
		for (int i = 0; i < 10; i++)
			host.wr(ADDR_START_0 + i[7:0], 8'hA0 + i[7:0], 1'b0);
		for (int i = 0; i < 10; i++)
			rchk(ADDR_START_0 + i[7:0], 8'hA0 + i[7:0]);
		chk({sweepStartFreq, sweepFreqStep, sweepStepCount, settleCycleCount}, 80'hA0A1A2A3A4A5A6A7A8A9);
		host.wr(ADDR_CTRL_LO, 8'h08, 1'b0);
		chk(extClockSel, 1'b1);
		// Unused bit held high throughout the range sweep
		for (int r = 0; r < 4; r++)
		begin
			host.wr(ADDR_CTRL_HI, {5'h01, r[1:0], r[0]}, 1'b0);
			chk({excitationRange, gainTimesFive, sweepCmd}, {rmap[r], !r[0], 4'h0});
		end
		rchk(ADDR_CTRL_LO, 8'h08);
		host.wr(ADDR_CTRL_HI, 8'h10, 1'b0);
		chk({cmdStrobe, sweepArmed}, 2'h3);
		host.wr(ADDR_CTRL_LO, 8'h10, 1'b0);
		chk({softReset, sweepArmed, sweepStartFreq, sweepStepCount}, {2'h2, 24'hA0A1A2, 16'hA6A7});
		host.wr(ADDR_CTRL_HI, 8'h20, 1'b0);
		chk(sweepArmed, 1'b0);
		host.wr(ADDR_CTRL_HI, 8'h40, 1'b1);
		rchk(ADDR_CTRL_HI, 8'h20);
		host.wr(ADDR_STATUS, 8'h00, 1'b0);
		host.wr(ADDR_REAL_HI, 8'h00, 1'b0);
		rchk(ADDR_STATUS, 8'h3C);
		rchk(ADDR_REAL_HI, 8'h12);
		rchk(ADDR_IMAG_LO, 8'hEF);
		host.rd(8'h90, d, v, m);
		chk({d, v, m}, 10'h002);
		results();
	end
endmodule
